// ===== hw/sepc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz system clock
// Notes: Included by sepc_top and sepc_host_model by bare name
`ifndef SEPC_MAP_SVH
`define SEPC_MAP_SVH

// Register byte addresses
`define SEPC_ADDR_EVENT_MASK 8'hD7
`define SEPC_ADDR_PULSE_DUTY 8'hD8
`define SEPC_ADDR_READY_TO 8'hD9
`define SEPC_ADDR_LINK_SET 8'hDA
`define SEPC_ADDR_RESEED_EN 8'hDB

// Reset values
`define SEPC_RST_EVENT_MASK 8'h00
`define SEPC_RST_PULSE_DUTY 8'h00
`define SEPC_RST_READY_TO 8'h20
`define SEPC_RST_LINK_SET 8'h01
`define SEPC_RST_RESEED_EN 3'h7

// Global event mask fields
`define SEPC_MSK_NEARNESS 0
`define SEPC_MSK_RF_EVENT 1
`define SEPC_MSK_MAGNETIC 2
`define SEPC_MSK_BAND_CMP 3
`define SEPC_MSK_THERMAL 4
`define SEPC_MSK_DEV_STATE 5
`define SEPC_MSK_POWER_UNIT 6
`define SEPC_MSK_RF_ACTIVE 7

// Serial link settings fields
`define SEPC_LNK_STOP_HOLD 7
`define SEPC_LNK_FIXED_ONE 0

// Timing
`define SEPC_CLK_MHZ 50
`define SEPC_PWM_FREQ_HZ 1000
`define SEPC_PWM_PERIOD_CYC ((`SEPC_CLK_MHZ * 1000000) / `SEPC_PWM_FREQ_HZ)
`define SEPC_DUTY_STEPS 256
`define SEPC_TO_UNIT_US 320
`define SEPC_TO_UNIT_CYC (`SEPC_TO_UNIT_US * `SEPC_CLK_MHZ)

`endif

// ===== hw/sepc_pkg.sv
// Purpose: Types shared by the configuration block
// Assumes: Constants live in sepc_map.svh
// Notes: Window states for the communication window
package sepc_pkg;

  typedef enum logic [1:0] {
    SEPC_WIN_IDLE = 2'b00,
    SEPC_WIN_OPEN = 2'b01,
    SEPC_WIN_HOLD = 2'b10
  } sepc_win_t;

endpackage : sepc_pkg

// ===== hw/sepc_cfg_if.sv
// Purpose: Carrier between the top and its pulse and timer modules
// Assumes: Single clock domain
// Notes: Settings driven by the top and read by the leaves; pwm_out and tmr_expired driven by the leaves
`timescale 1ns/1ps
interface sepc_cfg_if;
  logic [7:0] duty;
  logic pwm_en;
  logic pwm_out;
  logic [7:0] to_value;
  logic tmr_start;
  logic tmr_cancel;
  logic tmr_expired;

  modport ctl (output duty, output pwm_en, input pwm_out,
               output to_value, output tmr_start, output tmr_cancel, input tmr_expired);
  modport pwm (input duty, input pwm_en, output pwm_out);
  modport tmr (input to_value, input tmr_start, input tmr_cancel, output tmr_expired);
endinterface : sepc_cfg_if

// ===== hw/sepc_pwm.sv
// Purpose: Fixed-frequency pulse generator
// Assumes: Duty step of period over 256
// Notes: Output low and counter parked while disabled
`timescale 1ns/1ps
module sepc_pwm
  import sepc_pkg::*;
#(
  parameter int PERIOD_CYC = 50000
)(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Configuration
  sepc_cfg_if.pwm cfg
);
  logic [15:0] cnt;
  logic [31:0] high_prod;
  logic [23:0] high_cyc;
  logic at_end;

  // [R7] high time threshold
  assign high_prod = (32'(cfg.duty) + 32'h1) * 32'(PERIOD_CYC);
  assign high_cyc = high_prod[31:8];
  // [R8] fixed period wrap
  assign at_end = (cnt == 16'(PERIOD_CYC - 1));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 16'h0;
    else if (!cfg.pwm_en || at_end)
      cnt <= 16'h0;
    else
      cnt <= cnt + 16'h1;
  end

  // [R9] gated by enable
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg.pwm_out <= 1'b0;
    else
      cfg.pwm_out <= cfg.pwm_en && ({8'h00, cnt} < high_cyc);
  end
endmodule : sepc_pwm

// ===== hw/sepc_win_timer.sv
// Purpose: Communication window no-start timeout
// Assumes: Timeout is value times one unit
// Notes: Value zero expires one cycle after start
`timescale 1ns/1ps
module sepc_win_timer
  import sepc_pkg::*;
#(
  parameter int UNIT_CYC = 16000
)(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  sepc_cfg_if.tmr cfg
);
  logic running;
  logic [15:0] sub_cnt;
  logic [7:0] units;
  logic unit_end;
  logic hit;

  assign unit_end = (sub_cnt == 16'(UNIT_CYC - 1));
  // [R10] value times unit
  assign hit = running && (units == cfg.to_value) && !cfg.tmr_start;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      running <= 1'b0;
      sub_cnt <= 16'h0;
      units <= 8'h00;
    end
    else if (cfg.tmr_cancel || hit)
    begin
      running <= 1'b0;
      sub_cnt <= 16'h0;
      units <= 8'h00;
    end
    else if (cfg.tmr_start)
    begin
      running <= 1'b1;
      sub_cnt <= 16'h0;
      units <= 8'h00;
    end
    else if (running)
    begin
      sub_cnt <= unit_end ? 16'h0 : sub_cnt + 16'h1;
      units <= unit_end ? units + 8'h01 : units;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfg.tmr_expired <= 1'b0;
    else
      cfg.tmr_expired <= hit && !cfg.tmr_cancel;
  end
endmodule : sepc_win_timer

// ===== hw/sepc_top.sv
// Purpose: Event mask, pulse output, ready timeout, link window and reseed enables
// Assumes: Register port, events and link strobes come from logic on clk
// Notes: Registers sit at their byte addresses on the register port
//
// Notes on behaviour
// [R1] Each of the eight mask bits passes its source when 0, blocks it when 1, reset all 0.
// [R2] Mask bit 7 gates reporting of the rf_exposure_active state.
// [R3] Mask bit 6 gates power_unit_event and bit 5 gates device_state_event.
// [R4] Mask bit 4 gates thermal_event.
// [R5] The band_compare_event mask sits at bit 3.
// [R6] Bit 2 gates magnetic_event, bit 1 rf_exposure_event, bit 0 nearness_event.
// [R7] The pulse high fraction is (duty value plus one) over 256.
// [R8] The pulse runs at a fixed 1 kHz on pulse_output_pin.
// [R9] The pulse runs only while the pulse_output_enable bit is set.
// [R10] The attention-line timeout is the stored value times 0.32 ms, reset 0x20.
// [R11] With stop_hold clear, a STOP closes the communication window.
// [R12] With stop_hold set, STOP is ignored and no START within the timeout closes it.
// [R13] The host writes link settings bit 0 as one and bits 6 to 1 as zero, reset 0x01.
// [R14] Reseed enable bits 2 to 0 enable automatic reseed of channels 2 to 0, reset 0x07.
// [R15] Reseed enables gate only the halt-timeout reseeds, not other requests.
// [R16] While the pulse runs, coil drive is off, inductive sensing blocked, normal power kept.
// [R17] A masked source sets no flag and raises no attention, measurement goes on.
`timescale 1ns/1ps
`include "sepc_map.svh"
module sepc_top
  import sepc_pkg::*;
#(
  parameter int PWM_PERIOD_CYC = `SEPC_PWM_PERIOD_CYC,
  parameter int TO_UNIT_CYC = `SEPC_TO_UNIT_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_ack,
  // Event sources, bits 6 to 0 as in the mask
  input wire logic [6:0] event_in,
  input wire logic rf_exposure_active,
  input wire logic flags_clear,
  output logic [7:0] event_flags,
  output logic attention_req,
  // Link strobes
  input wire logic i2c_start,
  input wire logic i2c_stop,
  output logic window_open,
  output logic window_timeout,
  // Power mode bit from the power settings
  input wire logic pulse_output_enable,
  // Pulse output and coil control
  output logic pulse_output_pin,
  output logic coil_drive_off,
  output logic inductive_sense_block,
  output logic force_normal_power,
  // Reseed requests
  input wire logic [2:0] halt_reseed_req,
  input wire logic [2:0] other_reseed_req,
  output logic [2:0] reseed_cmd
);
  sepc_cfg_if cfg_bus();

  logic [7:0] event_mask;
  logic [7:0] pulse_duty;
  logic [7:0] ready_timeout;
  logic stop_hold;
  logic fixed_one;
  logic [2:0] reseed_en;
  sepc_win_t win_state;
  sepc_win_t next_win;
  localparam logic [7:0] link_rst = `SEPC_RST_LINK_SET;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_addr);
    addr_hit = (a == ref_addr);
  endfunction : addr_hit

  // Address decode
  wire wr_mask = reg_wr && addr_hit(reg_addr, `SEPC_ADDR_EVENT_MASK);
  wire wr_duty = reg_wr && addr_hit(reg_addr, `SEPC_ADDR_PULSE_DUTY);
  wire wr_to = reg_wr && addr_hit(reg_addr, `SEPC_ADDR_READY_TO);
  wire wr_link = reg_wr && addr_hit(reg_addr, `SEPC_ADDR_LINK_SET);
  wire wr_reseed = reg_wr && addr_hit(reg_addr, `SEPC_ADDR_RESEED_EN);

  wire [7:0] link_view = {stop_hold, 6'h00, fixed_one};
  wire [7:0] reseed_view = {5'h00, reseed_en};
  wire [7:0] next_rdata =
    addr_hit(reg_addr, `SEPC_ADDR_EVENT_MASK) ? event_mask :
    addr_hit(reg_addr, `SEPC_ADDR_PULSE_DUTY) ? pulse_duty :
    addr_hit(reg_addr, `SEPC_ADDR_READY_TO) ? ready_timeout :
    addr_hit(reg_addr, `SEPC_ADDR_LINK_SET) ? link_view :
    addr_hit(reg_addr, `SEPC_ADDR_RESEED_EN) ? reseed_view : 8'h00;

  // [R1] mask register storage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      event_mask <= `SEPC_RST_EVENT_MASK;
    else if (wr_mask)
      event_mask <= reg_wdata;
  end

  // [R7] duty value storage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pulse_duty <= `SEPC_RST_PULSE_DUTY;
    else if (wr_duty)
      pulse_duty <= reg_wdata;
  end

  // [R10] timeout value storage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ready_timeout <= `SEPC_RST_READY_TO;
    else if (wr_to)
      ready_timeout <= reg_wdata;
  end

  // Link settings keep only bits 7 and 0
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stop_hold <= link_rst[`SEPC_LNK_STOP_HOLD];
      fixed_one <= link_rst[`SEPC_LNK_FIXED_ONE];
    end
    else if (wr_link)
    begin
      stop_hold <= reg_wdata[`SEPC_LNK_STOP_HOLD];
      // [R13] host keeps this one
      fixed_one <= reg_wdata[`SEPC_LNK_FIXED_ONE];
    end
  end

  // [R14] reseed enables
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reseed_en <= `SEPC_RST_RESEED_EN;
    else if (wr_reseed)
      reseed_en <= reg_wdata[2:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rd_ack <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
      reg_rd_ack <= reg_rd;
    end
  end

  // Event gating per source
  // [R2] activation state gate
  wire allow_rf_active = !event_mask[`SEPC_MSK_RF_ACTIVE];
  // [R3] power and state gates
  wire allow_power_unit = !event_mask[`SEPC_MSK_POWER_UNIT];
  wire allow_dev_state = !event_mask[`SEPC_MSK_DEV_STATE];
  // [R4] thermal gate
  wire allow_thermal = !event_mask[`SEPC_MSK_THERMAL];
  // [R5] band compare gate
  wire allow_band_cmp = !event_mask[`SEPC_MSK_BAND_CMP];
  // [R6] low source gates
  wire allow_magnetic = !event_mask[`SEPC_MSK_MAGNETIC];
  wire allow_rf_event = !event_mask[`SEPC_MSK_RF_EVENT];
  wire allow_nearness = !event_mask[`SEPC_MSK_NEARNESS];
  wire [6:0] allow_vec = {allow_power_unit, allow_dev_state, allow_thermal, allow_band_cmp,
                          allow_magnetic, allow_rf_event, allow_nearness};
  // [R17] only allowed events report
  wire [6:0] passed_events = event_in & allow_vec;
  wire active_report = rf_exposure_active && allow_rf_active;
  wire next_attention = (|passed_events) || (active_report && !event_flags[7]);

  // Set wins over clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      event_flags <= 8'h00;
    else
      event_flags <= {active_report, passed_events | (flags_clear ? 7'h00 : event_flags[6:0])};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      attention_req <= 1'b0;
    else
      attention_req <= next_attention;
  end

  // Communication window
  always_comb
  begin
    next_win = win_state;
    case (win_state)
      SEPC_WIN_IDLE:
        if (i2c_start)
          next_win = SEPC_WIN_OPEN;
      SEPC_WIN_OPEN:
        // [R11] stop closes window
        if (i2c_stop && !i2c_start)
          next_win = stop_hold ? SEPC_WIN_HOLD : SEPC_WIN_IDLE;
      SEPC_WIN_HOLD:
        // [R12] wait for start
        if (i2c_start)
          next_win = SEPC_WIN_OPEN;
        else if (cfg_bus.tmr_expired)
          next_win = SEPC_WIN_IDLE;
      default:
        next_win = SEPC_WIN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_state <= SEPC_WIN_IDLE;
      window_open <= 1'b0;
      window_timeout <= 1'b0;
    end
    else
    begin
      win_state <= next_win;
      window_open <= (next_win != SEPC_WIN_IDLE);
      window_timeout <= (win_state == SEPC_WIN_HOLD) && (next_win == SEPC_WIN_IDLE);
    end
  end

  // [R12] timer runs only in hold
  assign cfg_bus.tmr_start = (win_state == SEPC_WIN_OPEN) && i2c_stop && !i2c_start && stop_hold;
  assign cfg_bus.tmr_cancel = i2c_start;
  assign cfg_bus.to_value = ready_timeout;
  assign cfg_bus.duty = pulse_duty;
  // [R9] enable from power settings
  assign cfg_bus.pwm_en = pulse_output_enable;

  sepc_win_timer #(.UNIT_CYC(TO_UNIT_CYC)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .cfg(cfg_bus.tmr)
  );

  sepc_pwm #(.PERIOD_CYC(PWM_PERIOD_CYC)) u_pwm (
    .clk(clk),
    .arst_n(arst_n),
    .cfg(cfg_bus.pwm)
  );

  // [R8] pulse pin output
  assign pulse_output_pin = cfg_bus.pwm_out;

  // [R16] coil and power hold-off
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      coil_drive_off <= 1'b0;
      inductive_sense_block <= 1'b0;
      force_normal_power <= 1'b0;
    end
    else
    begin
      coil_drive_off <= pulse_output_enable;
      inductive_sense_block <= pulse_output_enable;
      force_normal_power <= pulse_output_enable;
    end
  end

  // [R15] gate only halt reseeds
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reseed_cmd <= 3'h0;
    else
      reseed_cmd <= (halt_reseed_req & reseed_en) | other_reseed_req;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_flag_needs_allow: assert property ( // [R1]
    ((event_flags[6:0] & ~$past(event_flags[6:0])) & ~$past(event_in & allow_vec)) == 7'h00)
    else $error("event flag set without an allowed event");

  a_active_follows_mask: assert property ( // [R2]
    event_flags[7] == ($past(rf_exposure_active) && !$past(event_mask[7])))
    else $error("activation report does not follow mask bit 7");

  a_power_unit_gate: assert property ( // [R3]
    event_in[6] && event_mask[6] && !event_flags[6] |=> !event_flags[6])
    else $error("masked power unit event reported");

  a_thermal_gate: assert property ( // [R4]
    event_in[4] && !event_mask[4] |=> event_flags[4])
    else $error("allowed thermal event not reported");

  a_band_cmp_gate: assert property ( // [R5]
    event_in[3] && event_mask[3] && !event_flags[3] |=> !event_flags[3])
    else $error("band compare not gated by bit 3");

  a_attn_masked_quiet: assert property ( // [R17]
    (event_mask == 8'hFF) && $past(event_mask == 8'hFF) |=> !attention_req)
    else $error("attention raised with every source masked");

  a_pwm_off_low: assert property ( // [R9]
    !pulse_output_enable |=> !pulse_output_pin)
    else $error("pulse output high while disabled");

  a_pwm_full_on: assert property ( // [R7]
    pulse_output_enable && (pulse_duty == 8'hFF) |=> pulse_output_pin)
    else $error("full duty pulse dropped low");

  a_coil_off_pwm: assert property ( // [R16]
    pulse_output_enable |=> coil_drive_off && force_normal_power && inductive_sense_block)
    else $error("coil drive not held off while pulsing");

  a_stop_closes: assert property ( // [R11]
    (win_state == SEPC_WIN_OPEN) && i2c_stop && !i2c_start && !stop_hold |=> !window_open)
    else $error("stop did not close the window");

  a_stop_holds: assert property ( // [R12]
    (win_state == SEPC_WIN_OPEN) && i2c_stop && stop_hold |=> window_open ##1 window_open)
    else $error("stop closed the window under stop hold");

  a_zero_to_expiry: assert property ( // [R10]
    cfg_bus.tmr_start && (ready_timeout == 8'h00) ##1 !i2c_start [*2] |-> ##1 !window_open)
    else $error("zero timeout did not close the window");

  a_reseed_gate: assert property ( // [R15]
    reseed_cmd == $past((halt_reseed_req & reseed_en) | other_reseed_req))
    else $error("reseed command gating wrong");

  a_unmapped_zero: assert property ( // [R14]
    reg_rd && addr_hit(reg_addr, `SEPC_ADDR_RESEED_EN) |=> reg_rdata[7:3] == 5'h00)
    else $error("reseed enable upper bits not zero");

  c_hold_timeout: cover property (window_timeout);
  c_pwm_toggle: cover property ($rose(pulse_output_pin) ##[1:1000] $fell(pulse_output_pin));
  c_masked_event: cover property (|(event_in & ~allow_vec));
  c_reseed_blocked: cover property (|(halt_reseed_req & ~reseed_en));
endmodule : sepc_top

// ===== verification/sepc_host_model.sv
// Purpose: Host side model driving the register port
// Assumes: One-cycle strobes, read answer one cycle after the strobe
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ps
`include "sepc_map.svh"
module sepc_host_model
  import sepc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_ack
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `SEPC_ADDR_LINK_SET)
      v = {d[7], 6'h00, 1'b1};
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ack);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    ack = reg_rd_ack;
  endtask : rd_reg
endmodule : sepc_host_model

// ===== verification/sepc_top_tb_top.sv
// Purpose: Self-checking bench for the configuration block
// Assumes: Short pulse period and timeout unit for run time
// Notes: Register traffic goes through the host model
`timescale 1ns/1ps
module sepc_top_tb_top
  import sepc_pkg::*;
;
  localparam int PER = 512;
  localparam int UNIT = 10;
  logic clk, arst_n, reg_wr, reg_rd, reg_rd_ack, flags_clear, rf_exposure_active;
  logic i2c_start, i2c_stop, window_open, window_timeout, pulse_output_enable;
  logic attention_req, pulse_output_pin, coil_drive_off, inductive_sense_block;
  logic force_normal_power, ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, event_flags, rd;
  logic [6:0] event_in;
  logic [2:0] halt_reseed_req, other_reseed_req, reseed_cmd;
  int error_cnt, total_checks, n;

  sepc_top #(.PWM_PERIOD_CYC(PER), .TO_UNIT_CYC(UNIT)) i_sepc_top (
    .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_ack(reg_rd_ack), .event_in(event_in),
    .rf_exposure_active(rf_exposure_active), .flags_clear(flags_clear),
    .event_flags(event_flags), .attention_req(attention_req),
    .i2c_start(i2c_start), .i2c_stop(i2c_stop), .window_open(window_open),
    .window_timeout(window_timeout), .pulse_output_enable(pulse_output_enable),
    .pulse_output_pin(pulse_output_pin), .coil_drive_off(coil_drive_off),
    .inductive_sense_block(inductive_sense_block),
    .force_normal_power(force_normal_power), .halt_reseed_req(halt_reseed_req),
    .other_reseed_req(other_reseed_req), .reseed_cmd(reseed_cmd)
  );

  sepc_host_model i_sepc_host_model (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack)
  );

  always #10 clk = ~clk;

  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp, input string msg);
    total_checks++;
    if (got != exp)
    begin
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
      error_cnt++;
    end
  endtask : chk_n

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sepc_host_model.wr_reg(a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string msg);
    i_sepc_host_model.rd_reg(a, rd, ack);
    chk({7'h00, ack}, 8'h01, "read ack");
    chk(rd, exp, msg);
  endtask : rc

  task automatic pulse_ev(input logic [6:0] v);
    @(posedge clk);
    event_in <= v;
    @(posedge clk);
    event_in <= 7'h00;
    #1;
  endtask : pulse_ev

  task automatic clear_flags;
    @(posedge clk);
    flags_clear <= 1'b1;
    @(posedge clk);
    flags_clear <= 1'b0;
    #1;
  endtask : clear_flags

  task automatic strobe(input logic s, input logic p);
    @(posedge clk);
    i2c_start <= s;
    i2c_stop <= p;
    @(posedge clk);
    i2c_start <= 1'b0;
    i2c_stop <= 1'b0;
    #1;
  endtask : strobe

  task automatic pwm_meas(input logic [7:0] d);
    int hi;
    int rs;
    logic pv;
    hi = 0;
    rs = 0;
    wr(8'hD8, d);
    @(posedge clk);
    pulse_output_enable <= 1'b1;
    repeat (PER + 4) @(posedge clk);
    #1;
    pv = pulse_output_pin;
    repeat (2 * PER)
    begin
      @(posedge clk);
      #1;
      if (pulse_output_pin === 1'b1)
        hi++;
      if (pulse_output_pin === 1'b1 && pv === 1'b0)
        rs++;
      pv = pulse_output_pin;
    end
    chk_n(hi, 2 * (((d + 1) * PER) / 256), "high cycles");
    chk_n(rs, (d == 8'hFF) ? 0 : 2, "period count");
    chk({5'h00, coil_drive_off, inductive_sense_block, force_normal_power},
        8'h07, "coil control");
    @(posedge clk);
    pulse_output_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({4'h0, pulse_output_pin, coil_drive_off, inductive_sense_block,
         force_normal_power}, 8'h00, "pulse off");
  endtask : pwm_meas

  task automatic rs_chk(input logic [7:0] en, input logic [2:0] h, input logic [2:0] o,
                        input logic [7:0] exp);
    wr(8'hDB, en);
    @(posedge clk);
    halt_reseed_req <= h;
    other_reseed_req <= o;
    @(posedge clk);
    halt_reseed_req <= 3'h0;
    other_reseed_req <= 3'h0;
    #1;
    chk({5'h00, reseed_cmd}, exp, "reseed cmd");
  endtask : rs_chk

  // Watchdog against a hang
  initial
  begin
    #(20 * 50000);
    error_cnt++;
    close_out();
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {flags_clear, rf_exposure_active, i2c_start, i2c_stop, pulse_output_enable} = 5'h00;
    event_in = 7'h00;
    halt_reseed_req = 3'h0;
    other_reseed_req = 3'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values and access kinds
    rc(8'hD7, 8'h00, "mask reset");
    rc(8'hD8, 8'h00, "duty reset");
    rc(8'hD9, 8'h20, "timeout reset");
    rc(8'hDA, 8'h01, "link reset");
    rc(8'hDB, 8'h07, "reseed reset");
    wr(8'hD9, 8'hFF);
    rc(8'hD9, 8'hFF, "timeout rw");
    wr(8'hDA, 8'hFF);
    rc(8'hDA, 8'h81, "link bits");
    wr(8'hDB, 8'hFF);
    rc(8'hDB, 8'h07, "reseed bits");
    wr(8'hDC, 8'h55);
    rc(8'hDC, 8'h00, "unmapped");
    // One source masked at a time
    for (n = 0; n < 7; n++)
    begin
      wr(8'hD7, 8'h01 << n);
      pulse_ev(7'h7F);
      chk({7'h00, attention_req}, 8'h01, "attention");
      chk(event_flags & 8'h7F, 8'h7F & ~(8'h01 << n), "flags");
      clear_flags();
      chk(event_flags & 8'h7F, 8'h00, "cleared");
    end
    wr(8'hD7, 8'hFF);
    pulse_ev(7'h7F);
    chk({event_flags[6:0], attention_req}, 8'h00, "all masked");
    // Activation state report
    wr(8'hD7, 8'h80);
    @(posedge clk);
    rf_exposure_active <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, event_flags[7]}, 8'h00, "active masked");
    wr(8'hD7, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, event_flags[7]}, 8'h01, "active shown");
    @(posedge clk);
    rf_exposure_active <= 1'b0;
    // Pulse output duty and period
    pwm_meas(8'h00);
    pwm_meas(8'h7F);
    pwm_meas(8'hFF);
    // Window closed by stop
    wr(8'hDA, 8'h01);
    strobe(1'b1, 1'b0);
    chk({7'h00, window_open}, 8'h01, "open");
    strobe(1'b0, 1'b1);
    chk({7'h00, window_open}, 8'h00, "stop closes");
    // Window held after stop until timeout
    wr(8'hD9, 8'h03);
    wr(8'hDA, 8'h81);
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    #1;
    chk({7'h00, window_open}, 8'h01, "held open");
    n = 0;
    while (window_timeout !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_n((n + 20 >= 3 * UNIT) && (n + 20 <= 3 * UNIT + 4), 1, "timeout span");
    chk({7'h00, window_open}, 8'h00, "timeout closes");
    // Start within the timeout keeps it open
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    repeat (10) @(posedge clk);
    strobe(1'b1, 1'b0);
    repeat (60) @(posedge clk);
    #1;
    chk({7'h00, window_open}, 8'h01, "start cancels");
    wr(8'hDA, 8'h01);
    strobe(1'b0, 1'b1);
    chk({7'h00, window_open}, 8'h00, "closed again");
    // Zero timeout closes two edges after the stop
    wr(8'hD9, 8'h00);
    wr(8'hDA, 8'h81);
    strobe(1'b1, 1'b0);
    strobe(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h00, window_open, window_timeout}, 8'h01, "zero timeout");
    // Reseed gating
    rs_chk(8'h05, 3'h7, 3'h0, 8'h05);
    rs_chk(8'h00, 3'h7, 3'h2, 8'h02);
    close_out();
  end
endmodule : sepc_top_tb_top
